// File: logic/cpu_operating_mode_control_pkg.sv
package comr_pkg;
   // ==========================================================
   // Register layout
   // ==========================================================
   localparam int unsigned REG_W = 32;
   localparam int unsigned MASK_W = 4;
   localparam int unsigned SPEC_BIT = 5;
   localparam int unsigned MSKSEL_BIT = 3;
   // Reserved field 31..6 holds 0xF, so bits 9..6 read as ones
   localparam logic [REG_W-1:0] RSVD_VALUE = 32'h000003C0;
   localparam logic [REG_W-1:0] LIVE_MASK = 32'h00000028;
   localparam logic SPEC_RESET = 1'b1;
   localparam logic MSKSEL_RESET = 1'b0;
   localparam logic [REG_W-1:0] RESET_WORD = 32'h000003E0;

   // ==========================================================
   // Update sequence
   // ==========================================================
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WRITTEN,
      SEQ_READBACK
   } comr_seq_e;
endpackage

// File: logic/cpu_operating_mode_control_reg.sv
// Function
// - Reserved bits read their initial values; writes to them are ignored.
// - New setting applies after write, one readback, then return or invalidate.
// - Bit 5 set enables speculative return fetch; clear forbids it.
// - Bit 3 set loads interrupt mask with accepted level; clear keeps it.
`timescale 1ns/1ps
module comr_reg (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic regWrite,
   input wire logic regWriteFromCpu,
   input wire logic [comr_pkg::REG_W-1:0] regWdata,
   input wire logic regRead,
   input wire logic exceptionReturnInstruction,
   input wire logic icacheBlockInvalidateInstruction,
   input wire logic intAccept,
   input wire logic [comr_pkg::MASK_W-1:0] intLevel,
   input wire logic [comr_pkg::MASK_W-1:0] statusInterruptMask,
   output logic [comr_pkg::REG_W-1:0] regRdata,
   output logic returnFetchSpeculation,
   output logic interruptMaskUpdateSelect,
   output logic maskLoad,
   output logic [comr_pkg::MASK_W-1:0] newStatusInterruptMask
);
   import comr_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   comr_seq_e seq_q;
   comr_seq_e seq_d;
   logic specShadow_q;
   logic specShadow_d;
   logic mskShadow_q;
   logic mskShadow_d;
   logic specLive_q;
   logic specLive_d;
   logic mskLive_q;
   logic mskLive_d;
   logic [REG_W-1:0] rdata_q;
   logic [REG_W-1:0] rdata_d;
   logic maskLoad_q;
   logic maskLoad_d;
   logic [MASK_W-1:0] newMask_q;
   logic [MASK_W-1:0] newMask_d;
   logic cpuWrite;
   logic applyNow;

   // Non-CPU writes are dropped: their timing against the pipeline is unknown
   assign cpuWrite = regWrite & regWriteFromCpu;
   // Return and invalidate count only once the readback has been seen
   assign applyNow = (seq_q == SEQ_READBACK) &
                     (exceptionReturnInstruction | icacheBlockInvalidateInstruction);

   // ==========================================================
   // Update sequence
   // ==========================================================
   always_comb begin
      seq_d = seq_q;
      specShadow_d = specShadow_q;
      mskShadow_d = mskShadow_q;
      specLive_d = specLive_q;
      mskLive_d = mskLive_q;
      if (cpuWrite) begin
         // Only live bits are stored; reserved bits stay constant
         specShadow_d = regWdata[SPEC_BIT];
         mskShadow_d = regWdata[MSKSEL_BIT];
         // A store in mid-sequence restarts it, so a stale readback never applies
         seq_d = SEQ_WRITTEN;
      end else begin
         case (seq_q)
            SEQ_IDLE: begin
               // Reads and returns here leave the live setting alone
               seq_d = SEQ_IDLE;
            end
            SEQ_WRITTEN: begin
               if (regRead) begin
                  seq_d = SEQ_READBACK;
               end
            end
            SEQ_READBACK: begin
               if (applyNow) begin
                  specLive_d = specShadow_q;
                  mskLive_d = mskShadow_q;
                  seq_d = SEQ_IDLE;
               end
            end
            default: begin
               seq_d = SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         seq_q <= SEQ_IDLE;
         specShadow_q <= SPEC_RESET;
         mskShadow_q <= MSKSEL_RESET;
         specLive_q <= SPEC_RESET;
         mskLive_q <= MSKSEL_RESET;
      end else begin
         seq_q <= seq_d;
         specShadow_q <= specShadow_d;
         mskShadow_q <= mskShadow_d;
         specLive_q <= specLive_d;
         mskLive_q <= mskLive_d;
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   always_comb begin
      rdata_d = rdata_q;
      if (regRead) begin
         // Readback shows what software wrote, before it takes effect
         rdata_d = RSVD_VALUE;
         rdata_d[SPEC_BIT] = specShadow_q;
         rdata_d[MSKSEL_BIT] = mskShadow_q;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= RESET_WORD;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Interrupt mask update
   // ==========================================================
   always_comb begin
      maskLoad_d = 1'b0;
      newMask_d = statusInterruptMask;
      if (intAccept) begin
         maskLoad_d = 1'b1;
         // Uses the applied bit, not the one still waiting in the shadow
         if (mskLive_q) begin
            newMask_d = intLevel;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         maskLoad_q <= 1'b0;
         newMask_q <= '0;
      end else begin
         maskLoad_q <= maskLoad_d;
         newMask_q <= newMask_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign regRdata = rdata_q;
   // Fetch unit must hold back speculative return fetches while this is low
   assign returnFetchSpeculation = specLive_q;
   assign interruptMaskUpdateSelect = mskLive_q;
   assign maskLoad = maskLoad_q;
   assign newStatusInterruptMask = newMask_q;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_RSVD_READ: assert property (
      regRead |=> ((regRdata & ~LIVE_MASK) == RSVD_VALUE))
      else $error("reserved bits read wrong value");

   AST_LIVE_READ: assert property (
      regRead |=> (regRdata[SPEC_BIT] == $past(specShadow_q))
         && (regRdata[MSKSEL_BIT] == $past(mskShadow_q)))
      else $error("live bits read back wrong value");

   AST_RDATA_HOLD: assert property (
      !regRead |=> $stable(regRdata))
      else $error("read data changed without a read");

   AST_NO_EARLY_APPLY: assert property (
      (seq_q != SEQ_READBACK) |=> $stable(returnFetchSpeculation))
      else $error("setting changed without full update sequence");

   AST_SEL_NO_EARLY: assert property (
      (seq_q != SEQ_READBACK) |=> $stable(interruptMaskUpdateSelect))
      else $error("mask select changed without full update sequence");

   AST_SEQ_RESTART: assert property (
      cpuWrite |=> (seq_q == SEQ_WRITTEN))
      else $error("store did not restart update sequence");

   AST_READ_ADVANCE: assert property (
      ((seq_q == SEQ_WRITTEN) && regRead && !cpuWrite) |=> (seq_q == SEQ_READBACK))
      else $error("readback did not advance update sequence");

   AST_APPLY: assert property (
      (applyNow && !cpuWrite) |=> (returnFetchSpeculation == $past(specShadow_q))
         && (seq_q == SEQ_IDLE))
      else $error("setting not applied after return or invalidate");

   AST_SEL_APPLY: assert property (
      (applyNow && !cpuWrite) |=> (interruptMaskUpdateSelect == $past(mskShadow_q)))
      else $error("mask select not applied after return or invalidate");

   AST_SPEC_FOLLOWS: assert property (
      (cpuWrite && !regWdata[SPEC_BIT]) ##1 (!cpuWrite && regRead) ##1
      (!cpuWrite && exceptionReturnInstruction) |=> !returnFetchSpeculation)
      else $error("speculation still on after clear sequence");

   AST_MASK_LOAD: assert property (
      intAccept |=> maskLoad &&
         (newStatusInterruptMask == ($past(mskLive_q) ? $past(intLevel)
                                     : $past(statusInterruptMask))))
      else $error("interrupt mask update wrong");

   AST_MASK_IDLE: assert property (
      !intAccept |=> !maskLoad)
      else $error("mask load without accepted interrupt");

   AST_FOREIGN_WRITE: assert property (
      (regWrite && !regWriteFromCpu) |=> $stable(specShadow_q) && $stable(mskShadow_q))
      else $error("non-CPU write altered register");
endmodule

// File: dv/test_cpu_operating_mode_register.sv
`timescale 1ns/1ps
module test_cpu_operating_mode_register;
   import comr_pkg::*;
   // ==========================================================
   // Stimulus and design
   // ==========================================================
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic regWrite = 1'b0;
   logic regWriteFromCpu = 1'b0;
   logic [31:0] regWdata = 32'h0;
   logic regRead = 1'b0;
   logic excRet = 1'b0;
   logic icInv = 1'b0;
   logic intAccept = 1'b0;
   logic [3:0] intLevel = 4'h0;
   logic [3:0] curMask = 4'h0;
   logic [31:0] regRdata;
   logic spec;
   logic sel;
   logic maskLoad;
   logic [3:0] newMask;
   int error_cnt = 0;
   int compares = 0;
   always #5 mclk = ~mclk;
   comr_reg comr_reg_inst (.mclk(mclk), .sys_rst(rst), .regWrite(regWrite),
      .regWriteFromCpu(regWriteFromCpu), .regWdata(regWdata), .regRead(regRead),
      .exceptionReturnInstruction(excRet), .icacheBlockInvalidateInstruction(icInv),
      .intAccept(intAccept), .intLevel(intLevel), .statusInterruptMask(curMask),
      .regRdata(regRdata), .returnFetchSpeculation(spec),
      .interruptMaskUpdateSelect(sel), .maskLoad(maskLoad),
      .newStatusInterruptMask(newMask));
   // ==========================================================
   // Access tasks
   // ==========================================================
   // Every strobe rises 1 ns after an edge and is dropped 1 ns after the next
   task automatic step();
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [31:0] d, logic cpu);
      regWrite = 1'b1;
      regWriteFromCpu = cpu;
      regWdata = d;
      step();
      regWrite = 1'b0;
   endtask
   task automatic rd(logic [31:0] exp);
      regRead = 1'b1;
      step();
      regRead = 1'b0;
      chk("regRdata", exp, regRdata);
   endtask
   task automatic irq(logic [3:0] lvl, logic [3:0] exp);
      intLevel = lvl;
      curMask = 4'h2;
      intAccept = 1'b1;
      step();
      intAccept = 1'b0;
      chk("maskLoad", 32'h1, maskLoad);
      chk("newMask", exp, newMask);
      step();
      chk("maskLoad", 32'h0, maskLoad);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // Sequence
   // ==========================================================
   initial begin
      repeat (4) @(posedge mclk);
      #1;
      rst = 1'b0;
      rd(RESET_WORD);
      chk("spec", SPEC_RESET, spec);
      chk("sel", MSKSEL_RESET, sel);
      wr(RSVD_VALUE, 1'b0);
      rd(RESET_WORD);
      wr(RSVD_VALUE | 32'h00000008, 1'b1);
      // Return before the readback must not apply the new setting
      excRet = 1'b1;
      step();
      excRet = 1'b0;
      chk("spec", 32'h1, spec);
      rd(RSVD_VALUE | 32'h8);
      chk("spec", 32'h1, spec);
      icInv = 1'b1;
      step();
      icInv = 1'b0;
      chk("spec", 32'h0, spec);
      chk("sel", 32'h1, sel);
      irq(4'h5, 4'h5);
      wr(RESET_WORD, 1'b1);
      rd(RESET_WORD);
      excRet = 1'b1;
      step();
      excRet = 1'b0;
      chk("spec", 32'h1, spec);
      chk("sel", 32'h0, sel);
      irq(4'h5, 4'h2);
      // Back-to-back store, readback and return clear the speculation bit
      wr(RSVD_VALUE | 32'h00000008, 1'b1);
      rd(RSVD_VALUE | 32'h00000008);
      excRet = 1'b1;
      step();
      excRet = 1'b0;
      chk("spec", 32'h0, spec);
      chk("sel", 32'h1, sel);
      irq(4'h7, 4'h7);
      // Reset in mid-run brings back the initial setting
      rst = 1'b1;
      step();
      rst = 1'b0;
      chk("spec", SPEC_RESET, spec);
      chk("sel", MSKSEL_RESET, sel);
      rd(RESET_WORD);
      results();
   end
endmodule
